// ---- src/capture_timer.sv ----
/*
 * Free-running 16-bit timer with overflow flag, alternate count view,
 * buffered byte reads, external clock option and two input captures,
 * reached over AXI4-Lite. Assumes the capture and external clock pins
 * are asynchronous and that the CPU interrupt mask and halt state come
 * from logic on sys_clk.
 */
// Contract
// - 16-bit free-running up-counter read as high and low byte registers.
// - Alternate count view returns same value; its low read keeps overflow.
// - Writing counter low or alternate low forces count to FFFC.
// - Reset value is FFFC in every mode; nothing else is reloaded.
// - Count advances at clock divided by 2, 4, 8 or external edges.
// - Restricted variant drops second capture; its flag stays zero.
// - High byte read first buffers the matching low byte.
// - Buffered low byte frozen until low read, despite repeated high reads.
// - After a completed sequence, low read returns the live low byte.
// - Overflow flag sets when count wraps from FFFF to 0000.
// - Overflow interrupt needs enable set and global mask clear; else pends.
// - Overflow flag clears by status read then counter low access.
// - Wait leaves counting alone; halt freezes it until wake-up.
// - Both clock-select bits high pick external clock; edge bit chooses.
// - External edges synchronised; source spaces them at least four clocks apart.
// - Each capture latches count on its pin's chosen edge.
// - Capture sets its flag; interrupt needs shared enable, mask clear.
// - One capture enable gates interrupts from both channels.
// - Capture flag clears by status read then that channel's low access.
// - Capture high read blocks captures until the low byte is read or written.
// - A new capture overwrites the register with the latest count.
// - One-pulse or PWM mode leaves only the second channel capturing.
// - Pins feed capture unless blocked by a pending high read, one-pulse/PWM (ch 1) or restricted (ch 2).
`timescale 1ns/1ps

module capture_timer #(
  parameter bit RESTRICTED = 1'b0,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire capture_timer_pkg::axil_in_type bus_in,
  output capture_timer_pkg::axil_out_type bus_out,
  // Pins
  input wire logic ext_clock_pin,
  input wire logic [1:0] capture_input_pin,
  // CPU state
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  // Interrupt request
  output logic timer_irq
);

  capture_timer_pkg::state_type st;
  capture_timer_pkg::state_type next_st;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic [7:0] wr_addr;
  logic wr_lane;
  logic [7:0] rd_addr;
  logic tick;
  logic int_tick;
  logic ext_edge;
  logic [2:0] div_mask;
  logic wr_cnt_low;
  logic wr_alt_low;
  logic rd_cnt_low;
  logic rd_alt_low;
  logic rd_status;
  logic any_high_rd;
  logic [1:0] cap_low_acc;
  logic [1:0] cap_high_rd;
  logic [1:0] cap_edge;
  logic [1:0] cap_enable;
  logic [1:0] pin_in;

  // Unbonded pins are held high, so they never show an edge
  assign pin_in[0] = CAP1_BONDED ? capture_input_pin[0] : 1'b1;
  assign pin_in[1] = CAP2_BONDED ? capture_input_pin[1] : 1'b1;

  assign bus_out.awready = !st.aw_got && !st.bvalid;
  assign bus_out.wready = !st.w_got && !st.bvalid;
  assign bus_out.bvalid = st.bvalid;
  assign bus_out.bresp = st.bresp;
  assign bus_out.arready = !st.rvalid;
  assign bus_out.rvalid = st.rvalid;
  assign bus_out.rdata = st.rdata;
  assign bus_out.rresp = st.rresp;
  assign timer_irq = st.irq;

  always_comb begin
    next_st = st;
    // Bus handshakes
    aw_hs = bus_in.awvalid && bus_out.awready;
    w_hs = bus_in.wvalid && bus_out.wready;
    ar_hs = bus_in.arvalid && bus_out.arready;
    wr_addr = st.aw_got ? st.aw_addr : {bus_in.awaddr[7:2], 2'h0};
    wr_lane = st.w_got ? st.w_lane : bus_in.wstrb[0];
    do_wr = (st.aw_got || aw_hs) && (st.w_got || w_hs);
    rd_addr = {bus_in.araddr[7:2], 2'h0};
    // Access decode; a byte register is written only through lane 0
    wr_cnt_low = do_wr && wr_lane && wr_addr == capture_timer_pkg::CNT_LOW_ADDR;
    wr_alt_low = do_wr && wr_lane && wr_addr == capture_timer_pkg::ALT_LOW_ADDR;
    rd_cnt_low = ar_hs && rd_addr == capture_timer_pkg::CNT_LOW_ADDR;
    rd_alt_low = ar_hs && rd_addr == capture_timer_pkg::ALT_LOW_ADDR;
    rd_status = ar_hs && rd_addr == capture_timer_pkg::STATUS_ADDR;
    any_high_rd = ar_hs && (rd_addr == capture_timer_pkg::CNT_HIGH_ADDR
        || rd_addr == capture_timer_pkg::ALT_HIGH_ADDR);
    cap_high_rd[0] = ar_hs && rd_addr == capture_timer_pkg::CAP1_HIGH_ADDR;
    cap_high_rd[1] = ar_hs && rd_addr == capture_timer_pkg::CAP2_HIGH_ADDR;
    cap_low_acc[0] = (ar_hs && rd_addr == capture_timer_pkg::CAP1_LOW_ADDR)
        || (do_wr && wr_addr == capture_timer_pkg::CAP1_LOW_ADDR);
    cap_low_acc[1] = (ar_hs && rd_addr == capture_timer_pkg::CAP2_LOW_ADDR)
        || (do_wr && wr_addr == capture_timer_pkg::CAP2_LOW_ADDR);

    // Synchronisers: stage 0 feeds only stage 1
    next_st.ext_sync = {st.ext_sync[1:0], ext_clock_pin};
    for (int i = 0; i < 2; i++) begin
      next_st.pin_sync[i] = {st.pin_sync[i][1:0], pin_in[i]};
    end
    if (st.settle != capture_timer_pkg::SETTLE_DONE) begin
      next_st.settle = st.settle + 2'h1;
    end

    // Prescaler and clock selection
    unique case (st.ctrl_two[capture_timer_pkg::CLK_SEL_LSB +: 2])
      capture_timer_pkg::CLK_DIV2: div_mask = capture_timer_pkg::MASK_DIV2;
      capture_timer_pkg::CLK_DIV4: div_mask = capture_timer_pkg::MASK_DIV4;
      default: div_mask = capture_timer_pkg::MASK_DIV8;
    endcase
    int_tick = (st.presc & div_mask) == div_mask;
    ext_edge = st.ctrl_two[capture_timer_pkg::EXT_EDGE_BIT]
        ? (!st.ext_sync[1] && st.ext_sync[2])
        : (st.ext_sync[1] && !st.ext_sync[2]);
    tick = !halt_mode && (st.settle == capture_timer_pkg::SETTLE_DONE)
        && ((st.ctrl_two[capture_timer_pkg::CLK_SEL_LSB +: 2]
        == capture_timer_pkg::CLK_EXT) ? ext_edge : int_tick);
    // Halt freezes the prescaler too, so counting resumes in phase
    if (!halt_mode) begin
      next_st.presc = st.presc + 3'h1;
    end

    // Counter
    if (wr_cnt_low || wr_alt_low) begin
      next_st.count = capture_timer_pkg::COUNT_RESET;
    end else if (tick) begin
      next_st.count = st.count + 16'h0001;
    end

    // Overflow flag: clear first so a simultaneous set wins
    if (rd_status && st.ovf_flag) begin
      next_st.ovf_armed = 1'b1;
    end
    if ((rd_cnt_low || wr_cnt_low) && st.ovf_armed) begin
      next_st.ovf_flag = 1'b0;
      next_st.ovf_armed = 1'b0;
    end
    if (tick && st.count == capture_timer_pkg::COUNT_TOP
        && !wr_cnt_low && !wr_alt_low) begin
      next_st.ovf_flag = 1'b1;
    end

    // Byte buffer shared by both count views
    if (any_high_rd && !st.buf_valid) begin
      next_st.low_buf = st.count[7:0];
      next_st.buf_valid = 1'b1;
    end
    if (rd_cnt_low || rd_alt_low) begin
      next_st.buf_valid = 1'b0;
    end

    // Capture channels
    cap_enable[0] = !st.ctrl_two[capture_timer_pkg::ONE_PULSE_BIT]
        && !st.ctrl_two[capture_timer_pkg::PWM_BIT];
    cap_enable[1] = !RESTRICTED;
    for (int i = 0; i < 2; i++) begin
      cap_edge[i] = st.settle == capture_timer_pkg::SETTLE_DONE
          && (((i == 0) ? st.ctrl_one[capture_timer_pkg::CAP1_EDGE_BIT]
          : st.ctrl_two[capture_timer_pkg::CAP2_EDGE_BIT])
          ? (st.pin_sync[i][1] && !st.pin_sync[i][2])
          : (!st.pin_sync[i][1] && st.pin_sync[i][2]));
      if (rd_status && st.cap_flag[i]) begin
        next_st.cap_armed[i] = 1'b1;
      end
      if (cap_low_acc[i]) begin
        next_st.cap_block[i] = 1'b0;
        if (st.cap_armed[i]) begin
          next_st.cap_flag[i] = 1'b0;
          next_st.cap_armed[i] = 1'b0;
        end
      end
      if (cap_high_rd[i]) begin
        next_st.cap_block[i] = 1'b1;
      end
      if (cap_edge[i] && cap_enable[i] && !st.cap_block[i]) begin
        next_st.cap[i] = st.count;
        next_st.cap_flag[i] = 1'b1;
      end
    end

    // Interrupt request, held pending by the flags themselves
    next_st.irq = !cpu_irq_mask
        && ((st.ovf_flag && st.ctrl_one[capture_timer_pkg::OVF_IE_BIT])
        || ((|st.cap_flag)
        && st.ctrl_one[capture_timer_pkg::CAP_IE_BIT]));

    // Write channel
    if (aw_hs) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = {bus_in.awaddr[7:2], 2'h0};
    end
    if (w_hs) begin
      next_st.w_got = 1'b1;
      next_st.w_data = bus_in.wdata[7:0];
      next_st.w_lane = bus_in.wstrb[0];
    end
    if (st.bvalid && bus_in.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = capture_timer_pkg::RESP_OKAY;
      unique case (wr_addr)
        capture_timer_pkg::CTRL_ONE_ADDR: begin
          if (wr_lane) begin
            next_st.ctrl_one = 6'((st.w_got ? st.w_data
                : bus_in.wdata[7:0]) & 8'h07);
          end
        end
        capture_timer_pkg::CTRL_TWO_ADDR: begin
          if (wr_lane) begin
            next_st.ctrl_two = st.w_got ? st.w_data[5:0]
                : bus_in.wdata[5:0];
          end
        end
        capture_timer_pkg::CNT_LOW_ADDR,
        capture_timer_pkg::ALT_LOW_ADDR,
        capture_timer_pkg::CAP1_LOW_ADDR,
        capture_timer_pkg::CAP2_LOW_ADDR: begin
          next_st.bresp = capture_timer_pkg::RESP_OKAY;
        end
        default: next_st.bresp = capture_timer_pkg::RESP_SLVERR;
      endcase
    end

    // Read channel
    if (st.rvalid && bus_in.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = capture_timer_pkg::RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      unique case (rd_addr)
        capture_timer_pkg::CTRL_ONE_ADDR: next_st.rdata[5:0] = st.ctrl_one;
        capture_timer_pkg::CTRL_TWO_ADDR: next_st.rdata[5:0] = st.ctrl_two;
        capture_timer_pkg::STATUS_ADDR: begin
          next_st.rdata[capture_timer_pkg::OVF_FLAG_BIT] = st.ovf_flag;
          next_st.rdata[capture_timer_pkg::CAP1_FLAG_BIT] = st.cap_flag[0];
          next_st.rdata[capture_timer_pkg::CAP2_FLAG_BIT] = st.cap_flag[1];
        end
        capture_timer_pkg::CNT_HIGH_ADDR,
        capture_timer_pkg::ALT_HIGH_ADDR: begin
          next_st.rdata[7:0] = st.count[15:8];
        end
        capture_timer_pkg::CNT_LOW_ADDR,
        capture_timer_pkg::ALT_LOW_ADDR: begin
          next_st.rdata[7:0] = st.buf_valid ? st.low_buf
              : st.count[7:0];
        end
        capture_timer_pkg::CAP1_HIGH_ADDR: next_st.rdata[7:0] = st.cap[0][15:8];
        capture_timer_pkg::CAP1_LOW_ADDR: next_st.rdata[7:0] = st.cap[0][7:0];
        capture_timer_pkg::CAP2_HIGH_ADDR: next_st.rdata[7:0] = st.cap[1][15:8];
        capture_timer_pkg::CAP2_LOW_ADDR: next_st.rdata[7:0] = st.cap[1][7:0];
        default: next_st.rresp = capture_timer_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.count <= capture_timer_pkg::COUNT_RESET;
      st.ctrl_one <= capture_timer_pkg::CTRL_RESET;
      st.ctrl_two <= capture_timer_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Checks
  a_write_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_cnt_low || wr_alt_low) |=> st.count == 16'hFFFC)
    else $error("count not reloaded after low write");
  a_overflow_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && st.count == 16'hFFFF && !wr_cnt_low && !wr_alt_low)
    |=> (st.ovf_flag && st.count == 16'h0000))
    else $error("overflow flag missed on wrap");
  a_alt_keeps_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_alt_low && st.ovf_flag && !wr_cnt_low) |=> st.ovf_flag)
    else $error("alternate low read cleared overflow");
  a_flag_two_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(st.ovf_flag) |-> $past(st.ovf_armed)
      && ($past(rd_cnt_low) || $past(wr_cnt_low)))
    else $error("overflow flag cleared without two steps");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_irq_mask |=> !timer_irq)
    else $error("interrupt raised while masked");
  a_irq_pending: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.cap_flag[0] && st.ctrl_one[1] && !cpu_irq_mask) |=> timer_irq)
    else $error("pending capture interrupt not raised");
  a_buffer_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.buf_valid && !rd_cnt_low && !rd_alt_low) |=> $stable(st.low_buf)
      && st.buf_valid)
    else $error("buffered low byte changed");
  a_capture_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.cap_block[0] && !cap_low_acc[0]) |=> $stable(st.cap[0]))
    else $error("capture taken while blocked");
  a_halt_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (halt_mode && !wr_cnt_low && !wr_alt_low) |=> $stable(st.count))
    else $error("count moved in halt");
  a_cap2_absent: assert property (@(posedge sys_clk) disable iff (!rst_n)
    RESTRICTED |-> !st.cap_flag[1])
    else $error("second capture flag set in restricted variant");
  a_div2_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.ctrl_two[1:0] == 2'h0 && !halt_mode && tick) |=> !tick)
    else $error("divide by two ticked twice in a row");
  a_reset_count: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> st.count == capture_timer_pkg::COUNT_RESET)
    else $error("count not at reset value after reset");
  a_high_buffers: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (any_high_rd && !st.buf_valid)
    |=> st.buf_valid && st.low_buf == $past(st.count[7:0]))
    else $error("low byte not buffered on high read");
  a_ovf_arm: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (rd_status && st.ovf_flag && !wr_cnt_low)
    |=> st.ovf_armed)
    else $error("status read did not arm overflow clear");
  a_ovf_irq: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (st.ovf_flag && st.ctrl_one[0] && !cpu_irq_mask)
    |=> timer_irq)
    else $error("pending overflow interrupt not raised");
  a_ext_no_edge: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (st.ctrl_two[1:0] == 2'h3 && !ext_edge
    && !wr_cnt_low && !wr_alt_low) |=> $stable(st.count))
    else $error("external clock mode counted without an edge");
  a_cap_latest: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (cap_edge[1] && cap_enable[1] && !st.cap_block[1])
    |=> st.cap[1] == $past(st.count) && st.cap_flag[1])
    else $error("capture did not store latest count");
  a_cap_clear: assert property (@(posedge sys_clk)
    disable iff (!rst_n) $fell(st.cap_flag[0])
    |-> $past(st.cap_armed[0]) && $past(cap_low_acc[0]))
    else $error("capture flag cleared without two steps");
  a_pulse_ch1_off: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (st.ctrl_two[4] || st.ctrl_two[5])
    |=> $stable(st.cap[0]))
    else $error("first capture moved in pulse mode");

  c_overflow: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st.ovf_flag));
  c_capture: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st.cap_flag[1]));
  c_sequence: cover property (@(posedge sys_clk) disable iff (!rst_n)
    any_high_rd ##[1:20] rd_cnt_low);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(timer_irq));
  c_blocked: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cap_edge[0] && st.cap_block[0]);

endmodule

// ---- src/capture_timer_pkg.sv ----
/*
 * Shared constants and carriers for the free-running capture timer:
 * register byte offsets, field positions, reset values, clock-select
 * codes, the AXI4-Lite carriers and the packed state of the timer.
 * Assumes an 8-bit AXI4-Lite byte address and 32-bit data.
 */
package capture_timer_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [7:0] CTRL_TWO_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] CNT_HIGH_ADDR = 8'h0C;
  localparam logic [7:0] CNT_LOW_ADDR = 8'h10;
  localparam logic [7:0] ALT_HIGH_ADDR = 8'h14;
  localparam logic [7:0] ALT_LOW_ADDR = 8'h18;
  localparam logic [7:0] CAP1_HIGH_ADDR = 8'h1C;
  localparam logic [7:0] CAP1_LOW_ADDR = 8'h20;
  localparam logic [7:0] CAP2_HIGH_ADDR = 8'h24;
  localparam logic [7:0] CAP2_LOW_ADDR = 8'h28;

  // timer_control_one fields
  localparam int OVF_IE_BIT = 0;
  localparam int CAP_IE_BIT = 1;
  localparam int CAP1_EDGE_BIT = 2;
  // timer_control_two fields
  localparam int CLK_SEL_LSB = 0;
  localparam int EXT_EDGE_BIT = 2;
  localparam int CAP2_EDGE_BIT = 3;
  localparam int ONE_PULSE_BIT = 4;
  localparam int PWM_BIT = 5;
  // timer_status_reg fields
  localparam int OVF_FLAG_BIT = 0;
  localparam int CAP1_FLAG_BIT = 1;
  localparam int CAP2_FLAG_BIT = 2;

  // Reset and reload values
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Clock-select codes and prescaler masks (divide by mask + 1)
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  // Pin synchroniser settle count before edges are trusted
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_in_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_out_type;

  typedef struct packed {
    logic [15:0] count;
    logic [2:0] presc;
    logic [5:0] ctrl_one;
    logic [5:0] ctrl_two;
    logic ovf_flag;
    logic ovf_armed;
    logic [1:0] cap_flag;
    logic [1:0] cap_armed;
    logic [1:0] cap_block;
    logic [1:0][15:0] cap;
    logic [7:0] low_buf;
    logic buf_valid;
    logic [2:0] ext_sync;
    logic [1:0][2:0] pin_sync;
    logic [1:0] settle;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } state_type;

endpackage

// ---- verification/capture_pins_model.sv ----
/*
 * Far-side pin model: external count clock and two capture inputs.
 * Assumes the caller enters each task just after a rising sys_clk edge.
 */
`timescale 1ns/1ps

module capture_pins_model (
  // Clock
  input wire logic sys_clk,
  // Pins toward the timer
  output logic ext_clock_pin,
  output logic [1:0] capture_input_pin
);
  initial begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 2'b00;
  end

  // Gap below four cycles is illegal, so callers never ask for it
  task automatic ext_pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk);
      ext_clock_pin <= 1'b1;
      repeat (gap) @(posedge sys_clk);
      ext_clock_pin <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // Waits out synchroniser and capture latency before returning
  task automatic cap_set(input int ch, input logic v);
    @(posedge sys_clk);
    capture_input_pin[ch] <= v;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ---- verification/test_capture_timer.sv ----
/*
 * Self-checking bench for the capture timer over AXI4-Lite.
 * Assumes the pin model drives the pins; reads are checked from a queue.
 */
`timescale 1ns/1ps

module test_capture_timer;
  logic sys_clk;
  logic rst_n;
  capture_timer_pkg::axil_in_type bus_in;
  capture_timer_pkg::axil_out_type bus_out;
  logic ext_clock_pin;
  logic [1:0] capture_input_pin;
  logic cpu_irq_mask;
  logic halt_mode;
  logic timer_irq;
  int num_errors;
  int cmp_count;
  logic [31:0] exp_q[$];
  logic [1:0] exp_bq[$];
  logic [7:0] rnd;
  logic [15:0] exp_cnt;

  capture_timer dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_in(bus_in),
    .bus_out(bus_out),
    .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin),
    .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode),
    .timer_irq(timer_irq)
  );

  capture_pins_model pins (
    .sys_clk(sys_clk),
    .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    exp_bq.push_back(resp);
    rnd = lfsr(rnd);
    bus_in.awaddr <= a;
    bus_in.awvalid <= 1'b1;
    bus_in.wdata <= {rnd, rnd, rnd, d};
    bus_in.wstrb <= 4'hF;
    bus_in.wvalid <= 1'b1;
    bus_in.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (!aw_ok && bus_out.awready === 1'b1) begin
        aw_ok = 1'b1;
        bus_in.awvalid <= 1'b0;
      end
      if (!w_ok && bus_out.wready === 1'b1) begin
        w_ok = 1'b1;
        bus_in.wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bus_out.bvalid !== 1'b1);
    bus_in.bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus_in.araddr <= a;
    bus_in.arvalid <= 1'b1;
    bus_in.rready <= 1'b1;
    do @(posedge sys_clk); while (bus_out.arready !== 1'b1);
    bus_in.arvalid <= 1'b0;
    do @(posedge sys_clk); while (bus_out.rvalid !== 1'b1);
    bus_in.rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read data is judged here, apart from the driver
  always @(posedge sys_clk) begin
    if (bus_out.rvalid === 1'b1 && bus_in.rready === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rdata unexpected", 32'h0, 32'hFFFF_FFFF);
      else
        chk("rdata", exp_q.pop_front(), bus_out.rdata);
    end
    if (bus_out.bvalid === 1'b1 && bus_in.bready === 1'b1) begin
      if (exp_bq.size() == 0)
        chk("bresp unexpected", 32'h0, 32'hFFFF_FFFF);
      else
        chk("bresp", {30'h0, exp_bq.pop_front()}, {30'h0, bus_out.bresp});
    end
  end

  // Interrupt output is registered, so allow the lag to settle
  task automatic irq_is(input logic e);
    repeat (3) @(posedge sys_clk);
    chk("timer_irq", {31'h0, e}, {31'h0, timer_irq});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("BAD watchdog expected done seen hang");
    print_verdict;
  end

  initial begin
    bus_in = '0;
    rst_n = 1'b0;
    cpu_irq_mask = 1'b1;
    halt_mode = 1'b1;
    rnd = 8'h61;
    num_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(capture_timer_pkg::CTRL_ONE_ADDR, 8'h00);
    rd(capture_timer_pkg::CTRL_TWO_ADDR, 8'h00);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h00);
    rd(capture_timer_pkg::CNT_HIGH_ADDR, 8'hFF);
    rd(capture_timer_pkg::CNT_LOW_ADDR, 8'hFC);
    $display("test reset done");
    // External clock, rising edge; halt freezes stray counting
    wr(capture_timer_pkg::CTRL_TWO_ADDR, 8'h03, 2'h0);
    wr(capture_timer_pkg::CNT_LOW_ADDR, rnd, 2'h0);
    halt_mode <= 1'b0;
    pins.ext_pulses(2, 4);
    rd(capture_timer_pkg::CNT_HIGH_ADDR, 8'hFF);
    pins.ext_pulses(3, 7);
    rd(capture_timer_pkg::ALT_HIGH_ADDR, 8'h00);
    rd(capture_timer_pkg::CNT_LOW_ADDR, 8'hFE);
    rd(capture_timer_pkg::CNT_LOW_ADDR, 8'h01);
    rd(capture_timer_pkg::ALT_HIGH_ADDR, 8'h00);
    rd(capture_timer_pkg::ALT_LOW_ADDR, 8'h01);
    $display("test buffered read done");
    rd(capture_timer_pkg::STATUS_ADDR, 8'h01);
    rd(capture_timer_pkg::ALT_LOW_ADDR, 8'h01);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h01);
    rd(capture_timer_pkg::CNT_LOW_ADDR, 8'h01);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h00);
    wr(capture_timer_pkg::CTRL_ONE_ADDR, 8'h01, 2'h0);
    wr(capture_timer_pkg::ALT_LOW_ADDR, rnd, 2'h0);
    pins.ext_pulses(4, 4);
    irq_is(1'b0);
    cpu_irq_mask <= 1'b0;
    irq_is(1'b1);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h01);
    rd(capture_timer_pkg::CNT_LOW_ADDR, 8'h00);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h00);
    irq_is(1'b0);
    $display("test overflow done");
    wr(capture_timer_pkg::CTRL_ONE_ADDR, 8'h04, 2'h0);
    pins.ext_pulses(3, 5);
    pins.cap_set(0, 1'b1);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h02);
    irq_is(1'b0);
    wr(capture_timer_pkg::CTRL_ONE_ADDR, 8'h06, 2'h0);
    irq_is(1'b1);
    rd(capture_timer_pkg::CAP1_HIGH_ADDR, 8'h00);
    pins.ext_pulses(1, 4);
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    rd(capture_timer_pkg::CAP1_LOW_ADDR, 8'h03);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h00);
    irq_is(1'b0);
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h02);
    rd(capture_timer_pkg::CAP1_HIGH_ADDR, 8'h00);
    rd(capture_timer_pkg::CAP1_LOW_ADDR, 8'h04);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h00);
    $display("test capture one done");
    // One-pulse mode on, channel 2 on falling edge
    wr(capture_timer_pkg::CTRL_TWO_ADDR, 8'h13, 2'h0);
    pins.ext_pulses(2, 4);
    pins.cap_set(1, 1'b1);
    pins.ext_pulses(1, 4);
    pins.cap_set(1, 1'b0);
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    rd(capture_timer_pkg::STATUS_ADDR, 8'h04);
    irq_is(1'b1);
    rd(capture_timer_pkg::CAP1_HIGH_ADDR, 8'h00);
    rd(capture_timer_pkg::CAP1_LOW_ADDR, 8'h04);
    rd(capture_timer_pkg::CAP2_HIGH_ADDR, 8'h00);
    rd(capture_timer_pkg::CAP2_LOW_ADDR, 8'h07);
    irq_is(1'b0);
    $display("test capture two done");
    wr(capture_timer_pkg::CNT_HIGH_ADDR, rnd, 2'h2);
    wr(capture_timer_pkg::CAP1_HIGH_ADDR, rnd, 2'h2);
    wr(8'h3C, rnd, 2'h2);
    $display("test bus errors done");
    // A window that is a multiple of the divisor hides prescaler phase
    halt_mode <= 1'b1;
    wr(capture_timer_pkg::CTRL_ONE_ADDR, 8'h00, 2'h0);
    for (int c = 0; c < 3; c++) begin
      wr(capture_timer_pkg::CTRL_TWO_ADDR, 8'(c), 2'h0);
      wr(capture_timer_pkg::CNT_LOW_ADDR, rnd, 2'h0);
      halt_mode <= 1'b0;
      repeat (16) @(posedge sys_clk);
      halt_mode <= 1'b1;
      @(posedge sys_clk);
      exp_cnt = capture_timer_pkg::COUNT_RESET + 16'(16 >> (c + 1));
      rd(capture_timer_pkg::ALT_HIGH_ADDR, exp_cnt[15:8]);
      rd(capture_timer_pkg::ALT_LOW_ADDR, exp_cnt[7:0]);
    end
    $display("test prescaler done");
    repeat (4) @(posedge sys_clk);
    print_verdict;
  end
endmodule
